// file: core/ccp_pkg.sv
// Package for the capture/compare unit: register map, field layout, modes
package ccp_pkg;
    localparam int unsigned ADDR_W = 2;
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_VALUE_LOW = 2'h1;
    localparam logic [1:0] ADDR_VALUE_HIGH = 2'h2;
    localparam logic [1:0] ADDR_STATUS = 2'h3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WR_MASK = 8'hbf;
    localparam logic [7:0] VALUE_RESET = 8'h00;
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_SET_HIGH = 4'h8;
    localparam logic [3:0] MODE_SET_LOW = 4'h9;
    localparam logic [3:0] MODE_SOFT_IRQ = 4'ha;
    localparam logic [3:0] MODE_SPECIAL = 4'hb;
    localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hf;
    localparam logic [3:0] PRESCALE_ZERO = 4'h0;
    localparam logic [3:0] PRESCALE_ONE = 4'h1;
    localparam int unsigned STATUS_FLAG_BIT = 0;
    localparam int unsigned STATUS_PIN_BIT = 1;
    localparam int unsigned STATUS_OWN_BIT = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic       out;
        logic       oe;
        logic       owned;
    } pin_drive_t;
endpackage

// file: core/capture_compare_unit.sv
// Capture/compare unit with PWM pin ownership, one system clock domain
// Operation
// (RULE1) Capture copies timer1 count, sets flag
// (RULE2) Mode codes choose capture edge and prescale
// (RULE3) Timer1 must be timer or synchronized counter
// (RULE4) Software masks and clears flag after mode change
// (RULE5) Prescaler cleared on reset, off, non-capture
// (RULE6) Prescaler kept across prescale setting changes
// (RULE7) Compare value pair against timer1 continuously
// (RULE8) Match toggles, sets, clears, triggers, interrupts
// (RULE9) Compare codes 0010, 1000, 1001, 1010, 1011
// (RULE10) Every compare match sets the flag
// (RULE11) Control write of zero clears compare latch
// (RULE12) Code 1010 flags only, pin untouched
// (RULE13) Code 1011 resets timer1, starts conversion
// (RULE14) Trigger immediate, timer clear on next tick
// (RULE15) Special trigger never sets timer1 overflow flag
// (RULE16) Removed match cancels pending timer1 reset
// (RULE17) Software sets pin direction to output
// (RULE18) PWM drives up to 10-bit waveform
// (RULE19) Software enables pin driver for PWM
// (RULE20) Control write zero returns pin to port
// (RULE21) Pin edges synchronised and counted once
module capture_compare_unit
    import ccp_pkg::*;
#(
    parameter int unsigned TIMER_W = 16,
    parameter int unsigned DUTY_W  = 10
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire ccp_pkg::reg_req_t     reg_req,
    output logic [7:0]                 reg_rdata,
    input  wire logic                  pin_in,
    input  wire logic [TIMER_W-1:0]    timer1_count,
    input  wire logic                  timer1_tick,
    input  wire logic                  adc_enabled,
    input  wire logic [DUTY_W-1:0]     pwm_time_base,
    input  wire logic                  pwm_period_start,
    input  wire logic                  flag_clear,
    output ccp_pkg::pin_drive_t        pin_drive,
    output logic                       ccp_interrupt_flag,
    output logic                       timer1_reset,
    output logic                       adc_start
);
    import ccp_pkg::*;

    logic [7:0]         control_reg;
    logic [7:0]         value_low_reg;
    logic [7:0]         value_high_reg;
    logic [2:0]         pin_sync_reg;
    logic [3:0]         prescale_reg;
    logic [3:0]         prescale_next;
    logic               latch_reg;
    logic               latch_next;
    logic               match_seen_reg;
    logic               reset_pending_reg;
    logic               flag_reg;
    logic [7:0]         rdata_reg;
    logic               pwm_out_reg;
    logic [DUTY_W-1:0]  duty_latch_reg;
    pin_drive_t         drive_reg;
    logic               adc_reg;
    logic               treset_reg;

    function automatic logic is_capture(input logic [3:0] m);
        return m[3:2] == MODE_CAP_FALL[3:2];
    endfunction

    function automatic logic is_compare(input logic [3:0] m);
        return m == MODE_TOGGLE || (m[3:2] == MODE_SET_HIGH[3:2]);
    endfunction

    wire [3:0]          mode = control_reg[3:0];
    wire                capture_mode = is_capture(mode);
    wire                compare_mode = is_compare(mode);
    wire                pwm_mode = mode[3:2] == 2'b11;
    wire [TIMER_W-1:0]  value_pair = {value_high_reg, value_low_reg};
    wire                wr_control = reg_req.wr && reg_req.addr == ADDR_CONTROL;
    wire                wr_low = reg_req.wr && reg_req.addr == ADDR_VALUE_LOW;
    // In PWM the high byte is the duty buffer, read only
    wire                wr_high = reg_req.wr && reg_req.addr == ADDR_VALUE_HIGH && !pwm_mode;
    wire                control_zero = wr_control && reg_req.wdata == CONTROL_RESET;

    // Only second and third stages are compared [RULE21]
    wire                pin_rise = pin_sync_reg[1] && !pin_sync_reg[2];
    wire                pin_fall = !pin_sync_reg[1] && pin_sync_reg[2];
    wire                rise_mode = mode != MODE_CAP_FALL;
    wire                edge_hit = capture_mode && (rise_mode ? pin_rise : pin_fall);
    wire [3:0]          prescale_last = mode == MODE_CAP_RISE4 ? PRESCALE_4_LAST :
                                        mode == MODE_CAP_RISE16 ? PRESCALE_16_LAST :
                                        PRESCALE_ZERO;
    // Count wraps at prescale_last; every-edge modes use last of zero [RULE2]
    wire                capture_now = edge_hit && prescale_reg >= prescale_last; // [RULE2]

    // Equality is level-tested every cycle; event is its rising edge [RULE7]
    wire                match_level = compare_mode && timer1_count == value_pair;
    wire                match_now = match_level && !match_seen_reg;
    wire                special_now = match_now && mode == MODE_SPECIAL;
    wire                pin_owned = (compare_mode && mode != MODE_SOFT_IRQ
                                     && mode != MODE_SPECIAL) || pwm_mode;
    wire [DUTY_W-1:0]   duty_word = {value_low_reg, control_reg[5:4]};
    wire                pwm_next = pwm_period_start ? (duty_word != '0) :
                                   (pwm_time_base == duty_latch_reg ? 1'b0 : pwm_out_reg);
    wire                flag_set = capture_now || match_now; // [RULE1] [RULE10]

    always_comb begin
        prescale_next = prescale_reg;
        if (!capture_mode) begin
            prescale_next = PRESCALE_ZERO; // [RULE5]
        end else if (edge_hit) begin
            // Setting changes keep the count; may fire early [RULE6]
            prescale_next = capture_now ? PRESCALE_ZERO : prescale_reg + PRESCALE_ONE; // [RULE21]
        end
    end

    always_comb begin
        latch_next = latch_reg;
        if (control_zero) begin
            latch_next = 1'b0; // [RULE11]
        end else if (match_now) begin
            unique case (mode)
                MODE_TOGGLE:   latch_next = !latch_reg; // [RULE8] [RULE9]
                MODE_SET_HIGH: latch_next = 1'b1; // [RULE9]
                MODE_SET_LOW:  latch_next = 1'b0; // [RULE9]
                default:       latch_next = latch_reg; // [RULE12]
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            control_reg <= CONTROL_RESET;
        end else if (wr_control) begin
            control_reg <= reg_req.wdata & CONTROL_WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            value_low_reg  <= VALUE_RESET;
            value_high_reg <= VALUE_RESET;
        end else if (capture_now) begin
            {value_high_reg, value_low_reg} <= timer1_count; // [RULE1]
        end else begin
            if (wr_low) begin
                value_low_reg <= reg_req.wdata;
            end
            if (wr_high) begin
                value_high_reg <= reg_req.wdata;
            end
            if (pwm_mode && pwm_period_start) begin
                value_high_reg <= value_low_reg; // [RULE18]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_sync_reg <= 3'h0;
            prescale_reg <= PRESCALE_ZERO; // [RULE5]
            latch_reg    <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], pin_in}; // [RULE21]
            prescale_reg <= prescale_next;
            latch_reg    <= latch_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else if (flag_set) begin
            flag_reg <= 1'b1; // Set wins over a same-cycle clear
        end else if (flag_clear) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            match_seen_reg    <= 1'b0;
            reset_pending_reg <= 1'b0;
        end else begin
            match_seen_reg <= match_level;
            if (special_now) begin
                reset_pending_reg <= 1'b1; // [RULE14]
            end else if (!match_level || mode != MODE_SPECIAL) begin
                reset_pending_reg <= 1'b0; // [RULE16]
            end else if (timer1_tick) begin
                reset_pending_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_out_reg    <= 1'b0;
            duty_latch_reg <= '0;
        end else if (!pwm_mode) begin
            pwm_out_reg <= 1'b0;
        end else begin
            pwm_out_reg <= pwm_next; // [RULE18]
            if (pwm_period_start) begin
                duty_latch_reg <= duty_word;
            end
        end
    end

    wire [7:0]          status_word = {5'h00, drive_reg.owned, latch_reg, flag_reg};

    always_ff @(posedge clk) begin
        if (rst) begin
            drive_reg <= '0;
        end else begin
            // Ownership tracks mode; writing zero releases pin [RULE20] [RULE12] [RULE13]
            drive_reg.owned <= pin_owned;
            drive_reg.oe    <= pin_owned;
            drive_reg.out   <= pwm_mode ? pwm_next : latch_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            adc_reg    <= 1'b0;
            treset_reg <= 1'b0;
        end else begin
            // Registered, so the trigger shows one cycle after the match [RULE14]
            adc_reg    <= special_now && adc_enabled; // [RULE13]
            // Timer reset only, never the overflow flag [RULE15]
            treset_reg <= reset_pending_reg && match_level && mode == MODE_SPECIAL
                          && timer1_tick; // [RULE13] [RULE14] [RULE16]
        end
    end

    // Data follow addr every cycle; rd has no side effects
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            unique case (reg_req.addr)
                ADDR_CONTROL:    rdata_reg <= control_reg;
                ADDR_VALUE_LOW:  rdata_reg <= value_low_reg;
                ADDR_VALUE_HIGH: rdata_reg <= value_high_reg;
                ADDR_STATUS:     rdata_reg <= status_word;
            endcase
        end
    end

    assign reg_rdata          = rdata_reg;
    assign pin_drive          = drive_reg;
    assign ccp_interrupt_flag = flag_reg;
    assign timer1_reset       = treset_reg;
    assign adc_start          = adc_reg;
endmodule

// file: dv/ccp_props.sv
// Port-level assertions for the capture/compare unit
module ccp_props
    import ccp_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst,
    input wire ccp_pkg::reg_req_t   reg_req,
    input wire logic                timer1_tick,
    input wire logic                adc_enabled,
    input wire logic                flag_clear,
    input wire ccp_pkg::pin_drive_t pin_drive,
    input wire logic                ccp_interrupt_flag,
    input wire logic                timer1_reset,
    input wire logic                adc_start
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic wr_ctl = reg_req.wr && reg_req.addr == ADDR_CONTROL;

    a_trig_sets_flag: assert property (adc_start |-> ccp_interrupt_flag)
        else $error("adc start without flag");
    a_adc_needs_enable: assert property (adc_start |-> $past(adc_enabled))
        else $error("adc start while converter off");
    a_reset_after_tick: assert property (timer1_reset |-> $past(timer1_tick))
        else $error("timer reset not on a timer edge");
    a_adc_one_cycle: assert property (adc_start |=> !adc_start)
        else $error("adc start longer than one cycle");
    a_ctl_zero_frees: assert property (wr_ctl && reg_req.wdata == 8'h00
        |-> ##2 !pin_drive.owned && !pin_drive.out) else $error("pin kept after zero write");
    a_irq_modes_no_pin: assert property (wr_ctl && reg_req.wdata[3:1] == 3'b101
        |-> ##2 !pin_drive.owned) else $error("pin taken in flag or trigger mode");
    a_reset_clears: assert property (disable iff (1'b0) rst
        |=> !ccp_interrupt_flag && !pin_drive.owned) else $error("outputs not cleared by reset");
    a_flag_sticky: assert property ($fell(ccp_interrupt_flag) && !$past(rst)
        |-> $past(flag_clear)) else $error("flag dropped without clear");

    c_capture: cover property ($rose(ccp_interrupt_flag));
    c_trigger: cover property (adc_start);
    c_timer_reset: cover property (timer1_reset);
endmodule

bind capture_compare_unit ccp_props i_ccp_props (
    .clk(clk), .rst(rst), .reg_req(reg_req), .timer1_tick(timer1_tick),
    .adc_enabled(adc_enabled), .flag_clear(flag_clear), .pin_drive(pin_drive),
    .ccp_interrupt_flag(ccp_interrupt_flag), .timer1_reset(timer1_reset),
    .adc_start(adc_start)
);

// file: dv/timer1_model.sv
// Timer1 time base model seen by the unit
module timer1_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    input  wire logic        timer1_reset,
    output logic             timer1_tick,
    output logic [15:0]      timer1_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // Synchronous counter on the system clock, one tick every two cycles
    always_ff @(posedge clk) begin
        timer1_tick <= run && !timer1_tick && !rst;
        if (rst) timer1_count <= 16'h0000;
        else if (load) timer1_count <= load_val;
        else if (timer1_reset) timer1_count <= 16'h0000;
        else if (timer1_tick) timer1_count <= timer1_count + 16'h0001;
    end
endmodule

// file: dv/capture_compare_unit_tb_top.sv
// Self-checking bench for the capture/compare unit
module capture_compare_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ccp_pkg::*;
    logic clk, rst, pin_in, run, load, flag_clear, tick, t1_rst, flag, adc_st;
    logic pstart, adc_en;
    logic [9:0]  tbase;
    logic [15:0] load_val, count;
    logic [7:0]  rdata, v;
    reg_req_t    req;
    pin_drive_t  drv;
    int          failures, compares, adc_seen;
    int          n [4] = '{1, 1, 4, 16};
    logic [3:0]  cmp_mode [6] = '{MODE_TOGGLE, MODE_SET_HIGH, MODE_SET_LOW,
                                  MODE_SOFT_IRQ, MODE_SPECIAL, MODE_SPECIAL};

    capture_compare_unit i_capture_compare_unit (.clk(clk), .rst(rst), .reg_req(req),
        .reg_rdata(rdata), .pin_in(pin_in), .timer1_count(count), .timer1_tick(tick),
        .adc_enabled(adc_en), .pwm_time_base(tbase), .pwm_period_start(pstart),
        .flag_clear(flag_clear), .pin_drive(drv), .ccp_interrupt_flag(flag),
        .timer1_reset(t1_rst), .adc_start(adc_st));
    timer1_model i_timer1_model (.clk(clk), .rst(rst), .run(run), .load(load),
        .load_val(load_val), .timer1_reset(t1_rst), .timer1_tick(tick),
        .timer1_count(count));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (adc_st === 1'b1) adc_seen++;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobe is released with one idle edge so back-to-back calls stay clean
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        // Data are registered from addr at the next edge and stay while addr is held
        @(negedge clk);
        v = rdata;
        check(v, exp);
        @(posedge clk);
    endtask
    // 0 loads the timer, 1 clears the flag, 2 starts a PWM period
    task automatic pulse(input int w);
        load       <= (w == 0);
        flag_clear <= (w == 1);
        pstart     <= (w == 2);
        @(posedge clk);
        {load, flag_clear, pstart} <= 3'b000;
        @(posedge clk);
    endtask
    task automatic step(input logic lvl);
        pin_in <= lvl;
        repeat (6) @(posedge clk);
    endtask
    task automatic pairs(input int k);
        repeat (k) begin
            step(1'b1);
            step(1'b0);
        end
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    initial begin
        {rst, pin_in, run, load, flag_clear, load_val} = {1'b1, 20'h0};
        {pstart, adc_en, tbase} = {1'b0, 1'b1, 10'h000};
        req = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(ADDR_CONTROL, CONTROL_RESET);
        check(v, CONTROL_RESET);
        wr(ADDR_CONTROL, 8'hff);
        rchk(ADDR_CONTROL, CONTROL_WR_MASK);
        rchk(ADDR_STATUS, 8'h04);
        wr(ADDR_CONTROL, 8'h00);
        rchk(ADDR_STATUS, 8'h00);
        load_val <= 16'h1234;
        pulse(0);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_CONTROL, {4'h0, MODE_CAP_FALL + 4'(i)});
            pulse(1);
            pairs(n[i] - 1);
            check(flag, 1'b0);
            step(1'b1);
            check(flag, i != 0);
            step(1'b0);
            check(flag, 1'b1);
            rchk(ADDR_VALUE_LOW, 8'h34);
            check(v, 8'h34);
            rchk(ADDR_VALUE_HIGH, 8'h12);
            check(v, 8'h12);
        end
        wr(ADDR_CONTROL, {4'h0, MODE_CAP_RISE4});
        pairs(3);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_CONTROL, {4'h0, MODE_CAP_RISE4});
        pulse(1);
        pairs(3);
        check(flag, 1'b0);
        wr(ADDR_CONTROL, {4'h0, MODE_CAP_RISE16});
        pulse(1);
        pairs(12);
        check(flag, 1'b0);
        pairs(1);
        check(flag, 1'b1);
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_CONTROL, 8'h00);
            load_val <= 16'h0000;
            adc_en <= (i != 5);
            pulse(0);
            wr(ADDR_VALUE_LOW, 8'h10);
            wr(ADDR_VALUE_HIGH, 8'h00);
            wr(ADDR_CONTROL, {4'h0, cmp_mode[i]});
            pulse(1);
            check(flag, 1'b0);
            run <= 1'b1;
            repeat (100) if (flag !== 1'b1) @(posedge clk);
            repeat (4) @(posedge clk);
            run <= 1'b0;
            check(flag, 1'b1);
            check(drv.out, 5'b00011 >> i & 1);
            check(drv.owned, 5'b00111 >> i & 1);
            check(drv.oe, 5'b00111 >> i & 1);
            check(count < 16'h0010, i >= 4);
            wr(ADDR_CONTROL, 8'h00);
            rchk(ADDR_STATUS, 8'h01);
            check(v[2:1], 2'b00);
        end
        check(adc_seen, 1);
        wr(ADDR_VALUE_LOW, 8'h01);
        wr(ADDR_CONTROL, 8'h0c);
        pulse(2);
        check(drv.out, 1'b1);
        check(drv.oe, 1'b1);
        tbase <= 10'h004;
        repeat (2) @(posedge clk);
        check(drv.out, 1'b0);
        wr(ADDR_VALUE_HIGH, 8'h55);
        rchk(ADDR_VALUE_HIGH, 8'h01);
        wr(ADDR_CONTROL, 8'h00);
        repeat (2) @(posedge clk);
        check(drv.owned, 1'b0);
        report_and_stop();
    end
endmodule
